// file: src/rms_regs.svh
// Register offsets, field positions and reset values for the misc status slice
`ifndef RMS_REGS_SVH
`define RMS_REGS_SVH

// ****************************************************************
// Register indices (printed offsets are not all word aligned)
// ****************************************************************
`define RMS_IDX_EDGE_STATUS   8'h1c
`define RMS_IDX_RSVD_1D       8'h1d
`define RMS_IDX_FORCE_CHANGE  8'h1e
`define RMS_IDX_RATE_SHADOW   8'h1f
`define RMS_IDX_FIFO_SHADOW   8'h20
`define RMS_IDX_IRQ_MASK      8'h30

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define RMS_EDGE_BITS         6
`define RMS_EDGE_RST          8'h00
`define RMS_FORCE_RST         2'h3
`define RMS_FORCE_D0          0
`define RMS_FORCE_D1          1
`define RMS_RATE_RSVD_MASK    8'hdf
`define RMS_FIFO_RSVD_MASK    8'hcf

`endif

// file: src/rms_pkg.sv
// Types shared by the misc status slice
package rms_pkg;
  // APB slave phase
  typedef enum logic [1:0] {
    RMS_IDLE   = 2'b01,
    RMS_ACCESS = 2'b10
  } rms_apb_state_t;
endpackage

// file: src/rms_edge_detect.sv
// Synchroniser and either-edge detector for the general purpose event pins
module rms_edge_detect #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins and events
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] sync1_q;  // First stage, read only by second
  logic [WIDTH-1:0] sync2_q;  // Second stage
  logic [WIDTH-1:0] prev_q;   // Delayed copy for edge compare
  logic [2:0]       fill_q;   // Ones shift in as the chain fills after reset

  // ****************************************************************
  // Two-stage synchroniser then history
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
      fill_q  <= 3'h0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      fill_q  <= {fill_q[1:0], 1'b1};
    end
  end

  // Either edge gives a one-cycle pulse, held off until the chain has filled
  // after reset, so a pin already high at release raises no false event; the
  // cost is that a pin change before the first clock after release is missed
  assign edge_pulse = (sync2_q ^ prev_q) & {WIDTH{fill_q[2]}};
endmodule

// file: src/rms_misc_regs.sv
// APB register slice: edge event status, force media change and two shadows
//
// The APB interface to the registers was chosen for this implementation.
`include "rms_regs.svh"

// Overview of operation
// - Writing one clears status bits 5:0
// - Either edge on pin sets sticky bit
// - Status bits 7:6 read zero
// - Status resets to zero
// - Location 0x1d reads zero
// - Force bits reset to ones
// - Software sets force bits, never clears
// - Step with select clears force bit
// - Media change flag from select, force, input
// - Rate shadow layout, bit 5 zero
// - Serial FIFO shadow layout, bits 5:4 zero
module rms_misc_regs #(
  parameter int EDGE_BITS = `RMS_EDGE_BITS
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Event pins
  input  wire logic [EDGE_BITS-1:0] edge_pin,
  // Floppy drive signals
  input  wire logic                 step_pulse_n,
  input  wire logic                 drive_select0_n,
  input  wire logic                 drive_select1_n,
  input  wire logic                 media_changed_in_n,
  output logic                      media_changed_flag,
  // Write-only source registers seen by the shadows
  input  wire logic                 rate_wr_stb,
  input  wire logic [7:0]           rate_wr_data,
  input  wire logic                 fifo_wr_stb,
  input  wire logic [7:0]           fifo_wr_data,
  // Interrupt
  output logic                      irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rms_pkg::rms_apb_state_t state_q;           // Bus phase
  rms_pkg::rms_apb_state_t state_d;
  logic [EDGE_BITS-1:0]    status_q;          // Sticky edge events
  logic [EDGE_BITS-1:0]    status_d;
  logic [EDGE_BITS-1:0]    mask_q;            // Interrupt mask, one enables
  logic [1:0]              force_q;           // Force media change bits
  logic [1:0]              force_d;
  logic [7:0]              rate_q;            // Floppy rate shadow
  logic [7:0]              fifo_q;            // Serial FIFO shadow
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    irq_q;
  logic                    flag_q;
  logic [EDGE_BITS-1:0]    edge_pulse;        // From the detector
  logic [2:0]              fl_s1_q;           // Floppy pin first stage
  logic [2:0]              fl_s2_q;           // Floppy pin second stage
  logic                    media_changed_flag_s1_q;
  logic                    media_changed_flag_s2_q;
  logic                    step_prev_q;       // Step history for edge

  // Byte address to register index; the low two address bits are ignored
  function automatic logic [7:0] idx_of(input logic [11:0] a);
    idx_of = a[9:2];
  endfunction

  wire       setup     = psel && !penable;
  wire       take      = psel && penable && (state_q == rms_pkg::RMS_ACCESS);
  wire [7:0] idx       = idx_of(paddr);
  wire       lane0     = pstrb[0];
  wire       hit_stat  = (idx == `RMS_IDX_EDGE_STATUS);
  wire       hit_rsvd  = (idx == `RMS_IDX_RSVD_1D);
  wire       hit_force = (idx == `RMS_IDX_FORCE_CHANGE);
  wire       hit_rate  = (idx == `RMS_IDX_RATE_SHADOW);
  wire       hit_fifo  = (idx == `RMS_IDX_FIFO_SHADOW);
  wire       hit_mask  = (idx == `RMS_IDX_IRQ_MASK);
  wire       mapped    = (paddr[11:10] == 2'b00) && (hit_stat || hit_rsvd || hit_force
                         || hit_rate || hit_fifo || hit_mask);
  // A write lands at the access edge, where the master samples pready high
  wire       wr_ok     = take && pwrite && mapped && lane0;
  wire       wr_stat   = wr_ok && hit_stat;
  wire       wr_force  = wr_ok && hit_force;
  wire       wr_mask   = wr_ok && hit_mask;

  // Synchronised floppy pins, active high
  wire       step_now  = !fl_s2_q[0];
  wire       sel0      = !fl_s2_q[1];
  wire       sel1      = !fl_s2_q[2];
  wire       step_fall = step_now && !step_prev_q;

  // ****************************************************************
  // Edge detection on event pins
  // ****************************************************************
  rms_edge_detect #(
    .WIDTH (EDGE_BITS)
  ) u_edge (
    .clock      (clock),
    .rst_n      (rst_n),
    .pin_in     (edge_pin),
    .edge_pulse (edge_pulse)
  );

  // ****************************************************************
  // Floppy pin synchronisers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fl_s1_q     <= 3'h7;
      fl_s2_q     <= 3'h7;
      media_changed_flag_s1_q <= 1'b1;
      media_changed_flag_s2_q <= 1'b1;
      step_prev_q <= 1'b0;
    end else begin
      fl_s1_q     <= {drive_select1_n, drive_select0_n, step_pulse_n};
      fl_s2_q     <= fl_s1_q;
      media_changed_flag_s1_q <= media_changed_in_n;
      media_changed_flag_s2_q <= media_changed_flag_s1_q;
      step_prev_q <= step_now;
    end
  end

  // ****************************************************************
  // Next values of status and force bits
  // ****************************************************************
  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    status_d = status_q;
    if (wr_stat) begin
      status_d = status_q & ~pwdata[EDGE_BITS-1:0];
    end
    status_d = status_d | edge_pulse;
  end

  // Software may only set; step clears, and a software set wins over it
  always_comb begin
    force_d = force_q;
    if (step_fall && sel0) begin
      force_d[`RMS_FORCE_D0] = 1'b0;
    end
    if (step_fall && sel1) begin
      force_d[`RMS_FORCE_D1] = 1'b0;
    end
    if (wr_force) begin
      force_d = force_d | pwdata[1:0];
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      force_q  <= `RMS_FORCE_RST;
      mask_q   <= '0;
    end else begin
      status_q <= status_d;
      force_q  <= force_d;
      if (wr_mask) begin
        mask_q <= pwdata[EDGE_BITS-1:0];
      end
    end
  end

  // Shadows follow the write-only sources; reserved bits forced low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= 8'h00;
      fifo_q <= 8'h00;
    end else begin
      if (rate_wr_stb) begin
        rate_q <= rate_wr_data & `RMS_RATE_RSVD_MASK;
      end
      if (fifo_wr_stb) begin
        fifo_q <= fifo_wr_data & `RMS_FIFO_RSVD_MASK;
      end
    end
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit_stat:  rd_byte = {2'b00, status_q};
      hit_rsvd:  rd_byte = 8'h00;
      hit_force: rd_byte = {6'h00, force_q};
      hit_rate:  rd_byte = rate_q;
      hit_fifo:  rd_byte = fifo_q;
      hit_mask:  rd_byte = {2'b00, mask_q};
      default:   rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // APB phase machine: answers one cycle after setup, zero wait
  // ****************************************************************
  always_comb begin
    case (state_q)
      rms_pkg::RMS_IDLE:   state_d = setup ? rms_pkg::RMS_ACCESS : rms_pkg::RMS_IDLE;
      rms_pkg::RMS_ACCESS: state_d = rms_pkg::RMS_IDLE;
      default:             state_d = rms_pkg::RMS_IDLE;
    endcase
  end

  // Read data and error are registered in setup so outputs come from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= rms_pkg::RMS_IDLE;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      pready_q <= setup;
      if (setup) begin
        prdata_q  <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_q <= !mapped;
      end else if (take) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Media change flag and interrupt, both registered
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= (sel0 && force_q[`RMS_FORCE_D0]) ||
                (sel1 && force_q[`RMS_FORCE_D1]) || !media_changed_flag_s2_q;
      irq_q  <= |(status_q & mask_q);
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign media_changed_flag = flag_q;
  assign irq                = irq_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  status_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_stat && pwdata[0] && !edge_pulse[0]) |=> !status_q[0])
    else $error("status bit 0 not cleared by write one");

  status_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_stat && !pwdata[0] && status_q[0]) |=> status_q[0])
    else $error("status bit 0 cleared by write zero");

  edge_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(edge_pin[0]) |-> ##3 status_q[0])
    else $error("pin edge did not set status");

  status_upper_a: assert property (@(posedge clock) disable iff (!rst_n)
    (setup && !pwrite && hit_stat) |=> prdata[7:6] == 2'b00)
    else $error("reserved status bits read non-zero");

  rsvd_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    (setup && !pwrite && hit_rsvd) |=> prdata == 32'h0000_0000)
    else $error("reserved location read non-zero");

  force_no_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_force && force_q[0] && !(step_fall && sel0)) |=> force_q[0])
    else $error("software cleared force bit");

  step_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
    (step_fall && sel1 && !wr_force) |=> !force_q[1])
    else $error("step did not clear force bit 1");

  flag_force_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sel0 && force_q[0]) |=> media_changed_flag)
    else $error("forced media change not reported");

  shadow_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    rate_wr_stb |=> (rate_q == (($past(rate_wr_data)) & 8'hdf)))
    else $error("rate shadow mismatch");

  shadow_fifo_a: assert property (@(posedge clock) disable iff (!rst_n)
    fifo_wr_stb |=> (fifo_q[5:4] == 2'b00) && (fifo_q[3:0] == $past(fifo_wr_data[3:0])))
    else $error("fifo shadow mismatch");

  force_step0_a: assert property (@(posedge clock) disable iff (!rst_n)
    (step_fall && sel0 && !wr_force) |=> !force_q[0])
    else $error("step did not clear force bit 0");

  force_keep1_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_force && force_q[1] && !(step_fall && sel1)) |=> force_q[1])
    else $error("software cleared force bit 1");

  force_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_force && (pwdata[1:0] == 2'b11)) |=> (force_q == 2'b11))
    else $error("software set of force bits lost");

  flag_input_a: assert property (@(posedge clock) disable iff (!rst_n)
    !media_changed_flag_s2_q |=> media_changed_flag)
    else $error("drive change input not reported");

  flag_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!sel0 && !sel1 && media_changed_flag_s2_q) |=> !media_changed_flag)
    else $error("media change reported with no cause");

  status_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (status_q[1] && !(wr_stat && pwdata[1])) |=> status_q[1])
    else $error("status bit 1 lost without a clear");

  irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(status_q & mask_q)) |=> irq)
    else $error("unmasked event did not raise interrupt");

  irq_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(|(status_q & mask_q)) |=> !irq)
    else $error("interrupt high with no unmasked event");

  strobe_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
    (take && pwrite && hit_mask && !lane0) |=> $stable(mask_q))
    else $error("write without byte strobe changed mask");

  unmapped_err_a: assert property (@(posedge clock) disable iff (!rst_n)
    (setup && !mapped) |=> (pready && pslverr))
    else $error("unmapped access not refused");

  pready_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
endmodule

// file: bench/tb_rms_misc_regs.sv
// Self-checking testbench for the misc status register slice
`include "rms_regs.svh"

module tb_rms_misc_regs;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clock;              // 40 MHz system clock
  logic        rst_n;              // Async reset, active low
  logic        psel;               // APB select
  logic        penable;            // APB access phase
  logic        pwrite;             // APB direction
  logic [11:0] paddr;              // APB byte address
  logic [31:0] pwdata;             // APB write data
  logic [3:0]  pstrb;              // APB byte strobes
  logic [31:0] prdata;             // APB read data
  logic        pready;             // APB ready
  logic        pslverr;            // APB error
  logic [5:0]  edge_pin;           // Event pins
  logic        step_pulse_n;       // Head step, active low
  logic        drive_select0_n;    // Drive 0 select, active low
  logic        drive_select1_n;    // Drive 1 select, active low
  logic        media_changed_in_n; // Drive's own change line
  logic        media_changed_flag; // Reported media change
  logic        rate_wr_stb;        // Rate source write strobe
  logic [7:0]  rate_wr_data;       // Rate source write data
  logic        fifo_wr_stb;        // FIFO source write strobe
  logic [7:0]  fifo_wr_data;       // FIFO source write data
  logic        irq;                // Level interrupt
  int          seed;               // Fixed random seed
  int          bad_count;          // Mismatches seen
  int          check_count;        // Comparisons made
  logic [7:0]  exp_st;             // Expected status
  logic [5:0]  m;                  // Pins to toggle
  logic [7:0]  d;                  // Random byte
  logic [3:0]  strb;               // Strobes for the next transfer

  // ****************************************************************
  // Design
  // ****************************************************************
  rms_misc_regs u_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .edge_pin(edge_pin), .step_pulse_n(step_pulse_n),
    .drive_select0_n(drive_select0_n), .drive_select1_n(drive_select1_n),
    .media_changed_in_n(media_changed_in_n), .media_changed_flag(media_changed_flag),
    .rate_wr_stb(rate_wr_stb), .rate_wr_data(rate_wr_data), .fifo_wr_stb(fifo_wr_stb),
    .fifo_wr_data(fifo_wr_data), .irq(irq)
  );

  // Free running clock
  always #12.5 clock = ~clock;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Verdict, the only place the run ends
  task automatic results();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare a register byte
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask

  // Compare a single bit
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask

  // One APB transfer; an edge passes first so no strobe is driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    pstrb   <= strb;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      // No answer: count it and close the run
      bad_count++;
      $display("FAIL %0t: no pready", $time);
      results();
    end else begin
      rd      = prdata[7:0];
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Read and compare data and error
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic experr);
    logic [7:0] v;
    logic       e;
    apb(1'b0, idx, 8'h00, v, e);
    chk_reg(v, exp);
    chk_bit(e, experr);
  endtask

  // Write a register byte
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] v;
    logic       e;
    apb(1'b1, idx, wd, v, e);
  endtask

  // Let synchronisers and flag logic settle; margin over the 3 cycle path
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask

  // Step pulse, low then high
  task automatic pulse_step();
    step_pulse_n <= 1'b0;
    settle();
    step_pulse_n <= 1'b1;
    settle();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clock = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; pstrb = 4'h0; edge_pin = 6'h00;
    step_pulse_n = 1'b1; drive_select0_n = 1'b1; drive_select1_n = 1'b1;
    media_changed_in_n = 1'b1; rate_wr_stb = 1'b0; rate_wr_data = 8'h00;
    fifo_wr_stb = 1'b0; fifo_wr_data = 8'h00; seed = 69800; bad_count = 0;
    check_count = 0;
    strb = 4'hf;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, reserved and unmapped places
    rd_chk(`RMS_IDX_EDGE_STATUS, 8'h00, 1'b0);
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h03, 1'b0);
    rd_chk(`RMS_IDX_RATE_SHADOW, 8'h00, 1'b0);
    rd_chk(`RMS_IDX_RSVD_1D, 8'h00, 1'b0);
    wr(`RMS_IDX_RSVD_1D, 8'hff);
    rd_chk(`RMS_IDX_RSVD_1D, 8'h00, 1'b0);
    rd_chk(8'h21, 8'h00, 1'b1);
    // Either-edge events, then random write-one clears; last pass clears all
    exp_st = 8'h00;
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 6'h3f : 6'($random(seed));
      edge_pin <= edge_pin ^ m;
      settle();
      exp_st = exp_st | {2'b00, m};
      rd_chk(`RMS_IDX_EDGE_STATUS, exp_st, 1'b0);
      d = (i == 5) ? 8'hff : 8'($random(seed));
      wr(`RMS_IDX_EDGE_STATUS, d);
      exp_st = exp_st & ~d & 8'h3f;
      rd_chk(`RMS_IDX_EDGE_STATUS, exp_st, 1'b0);
    end
    // Interrupt raised, masked, cleared
    edge_pin <= edge_pin ^ 6'h05;
    settle();
    wr(`RMS_IDX_IRQ_MASK, 8'h04);
    settle();
    chk_bit(irq, 1'b1);
    wr(`RMS_IDX_IRQ_MASK, 8'h02);
    settle();
    chk_bit(irq, 1'b0);
    wr(`RMS_IDX_IRQ_MASK, 8'h3f);
    wr(`RMS_IDX_EDGE_STATUS, 8'h05);
    settle();
    chk_bit(irq, 1'b0);
    // Force bits: software never clears them, step with select does
    wr(`RMS_IDX_FORCE_CHANGE, 8'h00);
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h03, 1'b0);
    chk_bit(media_changed_flag, 1'b0);
    drive_select0_n <= 1'b0;
    settle();
    chk_bit(media_changed_flag, 1'b1);
    pulse_step();
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h02, 1'b0);
    chk_bit(media_changed_flag, 1'b0);
    drive_select0_n <= 1'b1;
    drive_select1_n <= 1'b0;
    settle();
    chk_bit(media_changed_flag, 1'b1);
    pulse_step();
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h00, 1'b0);
    chk_bit(media_changed_flag, 1'b0);
    media_changed_in_n <= 1'b0;
    settle();
    chk_bit(media_changed_flag, 1'b1);
    media_changed_in_n <= 1'b1;
    wr(`RMS_IDX_FORCE_CHANGE, 8'hfd);
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h01, 1'b0);
    // A write without the low byte strobe is ignored
    strb = 4'he;
    wr(`RMS_IDX_FORCE_CHANGE, 8'h02);
    strb = 4'hf;
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h01, 1'b0);
    // Shadows follow the last source write, reserved bits read zero
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : 8'($random(seed));
      rate_wr_stb  <= 1'b1;
      rate_wr_data <= d;
      fifo_wr_stb  <= 1'b1;
      fifo_wr_data <= ~d;
      @(posedge clock);
      rate_wr_stb  <= 1'b0;
      fifo_wr_stb  <= 1'b0;
      rd_chk(`RMS_IDX_RATE_SHADOW, d & 8'hdf, 1'b0);
      rd_chk(`RMS_IDX_FIFO_SHADOW, ~d & 8'hcf, 1'b0);
    end
    // Mid-run reset with pins held high: no false event, reset values return
    edge_pin <= 6'h3f;
    rst_n    <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    chk_bit(irq, 1'b0);
    chk_bit(media_changed_flag, 1'b1);
    rd_chk(`RMS_IDX_EDGE_STATUS, 8'h00, 1'b0);
    rd_chk(`RMS_IDX_FORCE_CHANGE, 8'h03, 1'b0);
    rd_chk(`RMS_IDX_FIFO_SHADOW, 8'h00, 1'b0);
    results();
  end
endmodule
